// *** verilog/tsc_pkg.sv ***
// timer section package: register map, control fields, shared types
// assumes an 8-bit register port with reads answered one cycle later
package tsc_pkg;
   localparam logic [7:0] ADDR_RUN_CTRL   = 8'h0e;
   localparam logic [7:0] ADDR_T0_CTRL    = 8'h0f;
   localparam logic [7:0] ADDR_RELOAD_HI  = 8'h10;
   localparam logic [7:0] ADDR_RELOAD_LO  = 8'h11;
   localparam logic [7:0] ADDR_COUNT_HI   = 8'h12;
   localparam logic [7:0] ADDR_COUNT_LO   = 8'h13;
   localparam int         RUN_POS         = 4;
   localparam int         CTRL_STOP_RX    = 7;
   localparam int         CTRL_START_LSB  = 4;
   localparam int         CTRL_AUTO       = 3;
   localparam int         CTRL_CLK_LSB    = 0;
   localparam logic [7:0] CTRL_MASK       = 8'hbb;
   localparam logic [7:0] RST_BYTE        = 8'h00;
   localparam logic [3:0] RST_RUN         = 4'h0;
   localparam int         RX_STOP_BITS    = 4;

   typedef enum logic [1:0] {START_NONE, START_TX_END, START_TRIM,
                             START_TRIM_UF} tsc_start_t;
   typedef enum logic [1:0] {CLK_FAST, CLK_SLOW, CLK_T2_UF,
                             CLK_T1_UF} tsc_clk_t;

   typedef struct packed {
      logic       stop_rx;
      tsc_start_t start_mode;
      logic       auto_reload;
      tsc_clk_t   clk_sel;
   } tsc_ctrl_t;

   typedef struct packed {
      logic [7:0] addr;
      logic [7:0] wdata;
      logic       wr;
      logic       rd;
   } tsc_bus_t;
endpackage

// *** verilog/tsc_timer_section.sv ***
// timer section: shared run control, timer zero control, reload and counter
// assumes ticks, receive bit strobes and underflows of siblings are
// synchronous to i_mclk; the trimming edge source is an external pin
`timescale 1ns/10ps
module tsc_timer_section
(
   input  wire logic             i_mclk,
   input  wire logic             i_resetn,
   input  wire tsc_pkg::tsc_bus_t i_bus,
   output logic [7:0]            o_rdata,
   input  wire logic             i_tick_fast,
   input  wire logic             i_tick_slow,
   input  wire logic             i_t1_underflow,
   input  wire logic             i_t2_underflow,
   input  wire logic             i_tx_end,
   input  wire logic             i_rx_bit,
   input  wire logic             i_rx_frame_start,
   input  wire logic             i_trim_pin,
   input  wire logic [3:1]       i_sib_stop,
   output logic [3:0]            o_run,
   output logic                  o_t0_underflow,
   output logic                  o_irq_flag
);
   tsc_pkg::tsc_ctrl_t ctrl_ff, nxt_ctrl;
   logic [7:0]  rel_hi_ff, nxt_rel_hi, rel_lo_ff, nxt_rel_lo;
   logic [15:0] cnt_ff, nxt_cnt;
   logic [3:0]  run_ff, nxt_run;
   logic [2:0]  rxc_ff, nxt_rxc;
   logic [2:0]  trim_sync_ff;
   logic        trim_lvl_ff, nxt_trim_lvl;
   logic        uf_ff, nxt_uf;
   logic [7:0]  rdata_ff, nxt_rdata;
   logic        wr_run, tick, trim_mode, trim_rise, start_ev, uf;

   assign wr_run    = i_bus.wr && i_bus.addr == tsc_pkg::ADDR_RUN_CTRL;
   assign trim_mode = ctrl_ff.start_mode[1];
   // trimming edge: the last two sync stages agree before a change is accepted
   always_comb
   begin
      nxt_trim_lvl = trim_lvl_ff;
      if (trim_sync_ff[2] == trim_sync_ff[1])
         nxt_trim_lvl = trim_sync_ff[2];
   end
   assign trim_rise = trim_mode && nxt_trim_lvl && !trim_lvl_ff;

   always_comb
   begin
      case (ctrl_ff.clk_sel)
         tsc_pkg::CLK_FAST:  tick = i_tick_fast;
         tsc_pkg::CLK_SLOW:  tick = i_tick_slow;
         tsc_pkg::CLK_T2_UF: tick = i_t2_underflow;
         tsc_pkg::CLK_T1_UF: tick = i_t1_underflow;
         default:            tick = 1'b0;
      endcase
   end

   // start event for timer zero: software, end of transmission, trim edge
   always_comb
   begin
      start_ev = wr_run && i_bus.wdata[0]
                 && i_bus.wdata[tsc_pkg::RUN_POS] && !run_ff[0];
      if (ctrl_ff.start_mode == tsc_pkg::START_TX_END && i_tx_end)
         start_ev = 1'b1;
      if (trim_rise && !run_ff[0])
         start_ev = 1'b1;
   end
   // a trim edge while running stops the timer instead of counting
   assign uf = run_ff[0] && !start_ev && !trim_rise && tick
               && cnt_ff == 16'h0000;

   always_comb
   begin
      nxt_ctrl   = ctrl_ff;
      nxt_rel_hi = rel_hi_ff;
      nxt_rel_lo = rel_lo_ff;
      if (i_bus.wr)
      begin
         case (i_bus.addr)
            tsc_pkg::ADDR_T0_CTRL:
               nxt_ctrl = tsc_pkg::tsc_ctrl_t'({i_bus.wdata[7],
                          i_bus.wdata[5:3], i_bus.wdata[1:0]});
            tsc_pkg::ADDR_RELOAD_HI: nxt_rel_hi = i_bus.wdata;
            tsc_pkg::ADDR_RELOAD_LO: nxt_rel_lo = i_bus.wdata;
            default: ;
         endcase
      end
   end

   always_comb
   begin
      nxt_run = run_ff;
      nxt_cnt = cnt_ff;
      nxt_rxc = rxc_ff;
      nxt_uf  = 1'b0;
      // siblings stop themselves; their own logic reports it here
      nxt_run[3:1] = run_ff[3:1] & ~i_sib_stop;
      if (wr_run)
      begin
         for (int n = 0; n < 4; n++)
            if (i_bus.wdata[n])
               nxt_run[n] = i_bus.wdata[n + tsc_pkg::RUN_POS];
      end
      if (i_rx_frame_start)
         nxt_rxc = 3'h0;
      else if (i_rx_bit && rxc_ff != 3'(tsc_pkg::RX_STOP_BITS))
         nxt_rxc = rxc_ff + 3'h1;
      if (start_ev)
      begin
         nxt_run[0] = 1'b1;
         nxt_cnt    = {rel_hi_ff, rel_lo_ff};
      end
      else if (run_ff[0])
      begin
         if (trim_rise)
            nxt_run[0] = 1'b0;
         else if (tick)
         begin
            if (cnt_ff == 16'h0000)
            begin
               nxt_uf = ctrl_ff.start_mode != tsc_pkg::START_TRIM;
               if (ctrl_ff.auto_reload)
                  nxt_cnt = {rel_hi_ff, rel_lo_ff};
               else
                  nxt_run[0] = 1'b0;
            end
            else
               nxt_cnt = cnt_ff - 16'h0001;
         end
         // stop on the fourth received bit unless trimming
         if (ctrl_ff.stop_rx && !trim_mode && i_rx_bit
             && rxc_ff == 3'(tsc_pkg::RX_STOP_BITS - 1))
            nxt_run[0] = 1'b0;
      end
   end

   always_comb
   begin
      nxt_rdata = tsc_pkg::RST_BYTE;
      if (i_bus.rd)
      begin
         case (i_bus.addr)
            tsc_pkg::ADDR_RUN_CTRL:  nxt_rdata = {run_ff, 4'h0};
            tsc_pkg::ADDR_T0_CTRL:
               nxt_rdata = {ctrl_ff.stop_rx, 1'b0, ctrl_ff.start_mode,
                            ctrl_ff.auto_reload, 1'b0, ctrl_ff.clk_sel};
            tsc_pkg::ADDR_RELOAD_HI: nxt_rdata = rel_hi_ff;
            tsc_pkg::ADDR_RELOAD_LO: nxt_rdata = rel_lo_ff;
            tsc_pkg::ADDR_COUNT_HI:  nxt_rdata = cnt_ff[15:8];
            tsc_pkg::ADDR_COUNT_LO:  nxt_rdata = cnt_ff[7:0];
            default:                 nxt_rdata = tsc_pkg::RST_BYTE;
         endcase
      end
   end

   always_ff @(posedge i_mclk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         ctrl_ff      <= '0;
         rel_hi_ff    <= tsc_pkg::RST_BYTE;
         rel_lo_ff    <= tsc_pkg::RST_BYTE;
         cnt_ff       <= 16'h0000;
         run_ff       <= tsc_pkg::RST_RUN;
         rxc_ff       <= 3'h0;
         trim_sync_ff <= 3'h0;
         trim_lvl_ff  <= 1'b0;
         uf_ff        <= 1'b0;
         rdata_ff     <= tsc_pkg::RST_BYTE;
      end
      else
      begin
         ctrl_ff      <= nxt_ctrl;
         rel_hi_ff    <= nxt_rel_hi;
         rel_lo_ff    <= nxt_rel_lo;
         cnt_ff       <= nxt_cnt;
         run_ff       <= nxt_run;
         rxc_ff       <= nxt_rxc;
         trim_sync_ff <= {trim_sync_ff[1:0], i_trim_pin};
         trim_lvl_ff  <= nxt_trim_lvl;
         uf_ff        <= nxt_uf;
         rdata_ff     <= nxt_rdata;
      end
   end

   assign o_rdata        = rdata_ff;
   assign o_run          = run_ff;
   assign o_t0_underflow = uf_ff;
   assign o_irq_flag     = uf_ff;

   chk_mask_keep: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      wr_run && i_bus.wdata[3:0] == 4'h0 && i_sib_stop == 3'h0 && !start_ev
      && !(run_ff[0] && (tick || i_rx_bit || trim_rise))
      |=> o_run == $past(o_run))
      else $error("masked write changed a run bit");
   chk_mask_set: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      wr_run && i_bus.wdata == 8'hff |=> o_run[3:1] == 3'h7)
      else $error("ff write did not start sibling timers");
   chk_start_load: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      start_ev |=> o_run[0] && cnt_ff == {$past(rel_hi_ff),
      $past(rel_lo_ff)})
      else $error("start event did not load reload value");
   chk_dec_one: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      run_ff[0] && tick && !start_ev && !trim_rise && cnt_ff != 16'h0000
      |=> cnt_ff == $past(cnt_ff) - 16'h0001)
      else $error("counter did not step down by one");
   chk_oneshot: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      uf && !ctrl_ff.auto_reload |=> !o_run[0])
      else $error("one-shot timer kept running");
   chk_reload: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      uf && ctrl_ff.auto_reload && !i_rx_bit && !wr_run
      |=> o_run[0] && cnt_ff == {$past(rel_hi_ff), $past(rel_lo_ff)})
      else $error("auto reload failed");
   chk_uf_flag: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      uf && ctrl_ff.start_mode != tsc_pkg::START_TRIM
      |=> o_irq_flag)
      else $error("underflow flag missing");
   chk_rx_stop: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      run_ff[0] && ctrl_ff.stop_rx && !trim_mode && i_rx_bit && !start_ev
      && !i_rx_frame_start && rxc_ff == 3'h3 |=> !o_run[0])
      else $error("receive stop did not halt timer");
   chk_tx_start: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      ctrl_ff.start_mode == tsc_pkg::START_TX_END && i_tx_end
      |=> o_run[0])
      else $error("end of transmission did not start timer");
   // trimming runs ignore received bits; only an edge, the count or a software write ends them
   chk_rx_ignore: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      run_ff[0] && trim_mode && i_rx_bit && !trim_rise && !tick && !wr_run
      |=> o_run[0])
      else $error("receive stop acted during trimming");
   // with no automatic start only software may start timer zero
   chk_no_auto: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      ctrl_ff.start_mode == tsc_pkg::START_NONE && !run_ff[0] && !wr_run
      |=> !o_run[0])
      else $error("timer started without a start event");
   // rising trim edges toggle the run state of timer zero
   chk_trim_stop: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      run_ff[0] && trim_rise
      |=> !o_run[0])
      else $error("trim edge did not stop timer");
   chk_trim_start: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      !run_ff[0] && trim_rise
      |=> o_run[0])
      else $error("trim edge did not start timer");
   // trimming without underflow never raises the flag
   chk_uf_quiet: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      uf && ctrl_ff.start_mode == tsc_pkg::START_TRIM
      |=> !o_irq_flag)
      else $error("underflow flag in trimming without underflow");
   // only the selected source may move the count
   chk_clk_fast: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      run_ff[0] && ctrl_ff.clk_sel == tsc_pkg::CLK_FAST && !i_tick_fast
      && !start_ev |=> cnt_ff == $past(cnt_ff))
      else $error("count moved without a selected tick");
   chk_cascade: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      run_ff[0] && ctrl_ff.clk_sel == tsc_pkg::CLK_T2_UF && i_t2_underflow
      && !start_ev && !trim_rise && cnt_ff != 16'h0000
      |=> cnt_ff == $past(cnt_ff) - 16'h0001)
      else $error("cascade underflow did not step the count");
   // reload writes during a run leave the count alone
   chk_reload_hold: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      run_ff[0] && i_bus.wr && !tick && !start_ev
      && (i_bus.addr == tsc_pkg::ADDR_RELOAD_HI
          || i_bus.addr == tsc_pkg::ADDR_RELOAD_LO)
      |=> $stable(cnt_ff))
      else $error("reload write disturbed the count");
   // register reads answer one cycle after the strobe
   chk_run_read: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      i_bus.rd && i_bus.addr == tsc_pkg::ADDR_RUN_CTRL
      |=> o_rdata == {$past(run_ff), 4'h0})
      else $error("run bits read back wrong");
   chk_count_read: assert property (
      @(posedge i_mclk) disable iff (!i_resetn)
      i_bus.rd && i_bus.addr == tsc_pkg::ADDR_COUNT_LO
      |=> {8'h00, o_rdata} == ($past(cnt_ff) & 16'h00ff))
      else $error("count low byte read back wrong");

   cov_uf: cover property (@(posedge i_mclk) disable iff (!i_resetn) uf);
   cov_rx_stop: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      run_ff[0] && ctrl_ff.stop_rx && i_rx_bit && rxc_ff == 3'h3);
   cov_trim: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      trim_rise ##[1:100] trim_rise);
   cov_cascade: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      run_ff[0] && ctrl_ff.clk_sel == tsc_pkg::CLK_T1_UF && tick);
   cov_reload: cover property (@(posedge i_mclk) disable iff (!i_resetn)
      uf && ctrl_ff.auto_reload);
endmodule

// *** sim/test_tsc_timer_section.sv ***
// bench for the timer section: register port tasks and timer zero runs
// assumes read data one cycle after the strobe and a 3-flop trim sync
`timescale 1ns/10ps
module test_tsc_timer_section;
   logic              i_mclk = 1'b0;
   logic              i_resetn = 1'b0;
   logic              i_trim_pin = 1'b0;
   tsc_pkg::tsc_bus_t i_bus = '0;
   logic [6:0]        ev = 7'h00;
   logic [7:0]        o_rdata;
   logic [3:0]        o_run;
   logic              o_t0_underflow, o_irq_flag, seen;
   int                fails = 0, checks_done = 0;
   always #10 i_mclk = ~i_mclk;
   tsc_timer_section u_tsc_timer_section
   (
      .i_mclk (i_mclk), .i_resetn (i_resetn), .i_bus (i_bus),
      .o_rdata (o_rdata), .i_tick_fast (ev[0]), .i_tick_slow (ev[1]),
      .i_t2_underflow (ev[2]), .i_t1_underflow (ev[3]),
      .i_tx_end (ev[4]), .i_rx_bit (ev[5]), .i_rx_frame_start (ev[6]),
      .i_sib_stop (3'h0), .i_trim_pin (i_trim_pin), .o_run (o_run),
      .o_t0_underflow (o_t0_underflow), .o_irq_flag (o_irq_flag)
   );
   task automatic chk(input string what, input logic [7:0] got,
                      input logic [7:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         fails++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic stop_test();
      $display("checks %0d mismatches %0d", checks_done, fails);
      if (fails == 0 && checks_done > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(posedge i_mclk);
      i_bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
      @(posedge i_mclk);
      i_bus.wr <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      @(posedge i_mclk);
      i_bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
      @(posedge i_mclk);
      i_bus.rd <= 1'b0;
      #1;
      chk($sformatf("register %h", a), o_rdata, exp);
   endtask
   task automatic pulse(input logic [6:0] m);
      @(posedge i_mclk);
      ev <= m;
      @(posedge i_mclk);
      ev <= 7'h00;
   endtask
   task automatic trim(input logic v);
      @(posedge i_mclk);
      i_trim_pin <= v;
      repeat (5) @(posedge i_mclk);
   endtask
   task automatic want_uf(input logic exp);
      seen = 1'b0;
      repeat (3)
      begin
         #1;
         seen = seen | (o_t0_underflow & o_irq_flag);
         @(posedge i_mclk);
      end
      chk("underflow and flag", {7'h00, seen}, {7'h00, exp});
   endtask
   initial
   begin
      repeat (5) @(posedge i_mclk);
      i_resetn <= 1'b1;
      for (int a = 14; a < 20; a++)
         rd(8'(a), tsc_pkg::RST_BYTE);
      wr(8'h0e, 8'hff);
      rd(8'h0e, 8'hf0);
      chk("run pins", {o_run, 4'h0}, 8'hf0);
      wr(8'h0e, 8'hf0);
      rd(8'h0e, 8'hf0);
      wr(8'h0e, 8'h02);
      rd(8'h0e, 8'hd0);
      wr(8'h0e, 8'h0f);
      wr(8'h10, 8'h00);
      wr(8'h11, 8'h01);
      wr(8'h0e, 8'h11);
      pulse(7'h01);
      pulse(7'h01);
      want_uf(1'b1);
      rd(8'h0e, 8'h00);
      wr(8'h0f, 8'h08);
      wr(8'h0e, 8'h11);
      wr(8'h11, 8'h00);
      rd(8'h13, 8'h01);
      rd(8'h12, 8'h00);
      pulse(7'h01);
      pulse(7'h01);
      want_uf(1'b1);
      rd(8'h0e, 8'h10);
      wr(8'h0e, 8'h01);
      for (int m = 0; m < 4; m++)
      begin
         wr(8'h0f, 8'h80 | 8'(m << 4));
         pulse(7'h10);
         rd(8'h0e, (m == 1) ? 8'h10 : 8'h00);
         if (m == 0)
            wr(8'h0e, 8'h11);
         if (m > 1)
            trim(1'b1);
         pulse(7'h40);
         repeat (3) pulse(7'h20);
         rd(8'h0e, 8'h10);
         pulse(7'h20);
         rd(8'h0e, (m < 2) ? 8'h00 : 8'h10);
         if (m > 1)
         begin
            trim(1'b0);
            trim(1'b1);
            rd(8'h0e, 8'h00);
            wr(8'h0e, 8'h11);
            pulse(7'h01);
            want_uf(m == 3);
            trim(1'b0);
            wr(8'h0e, 8'h01);
         end
      end
      wr(8'h11, 8'h05);
      for (int s = 0; s < 4; s++)
      begin
         wr(8'h0f, 8'(s));
         wr(8'h0e, 8'h11);
         pulse(7'h0f ^ (7'h01 << s));
         pulse(7'h01 << s);
         rd(8'h13, 8'h04);
         wr(8'h0e, 8'h01);
      end
      stop_test();
   end
endmodule
